/* src/hc_cmd_pkg.sv */
/*
  package for the command / status register bank of the host controller:
  offsets, field positions, reset values, masks and carrier structs.
  assumes a single pclk domain and an 8-bit APB byte address.
*/
`default_nettype none

package hc_cmd_pkg;

	// =====================================================================
	// register map
	// =====================================================================
	localparam logic [7:0]  CMD_OFFSET       = 8'h20;
	localparam logic [7:0]  STS_OFFSET       = 8'h24;

	// =====================================================================
	// controller_command fields
	// =====================================================================
	localparam int          CMD_RUN_BIT      = 0;
	localparam int          CMD_ASYNC_EN_BIT = 5;
	localparam int          CMD_DOORBELL_BIT = 6;
	localparam int          CMD_LIGHT_RST    = 7;
	localparam int          CMD_PARK_CNT_LO  = 8;
	localparam int          CMD_PARK_EN_BIT  = 11;
	localparam int          CMD_THRESH_LO    = 16;
	localparam logic [31:0] CMD_RESET        = 32'h0008_0B00;
	// writable storage bits: 5:0, 9:8, 11, 23:16 (doorbell handled apart)
	localparam logic [31:0] CMD_RW_MASK      = 32'h00FF_0B3F;
	localparam logic [31:0] CMD_DOORBELL_MSK = 32'h0000_0040;

	// =====================================================================
	// controller_status fields
	// =====================================================================
	localparam int          STS_ASYNC_ADV_BIT = 5;
	localparam logic        STS_FLAG_RESET    = 1'h0;

	// =====================================================================
	// timing and counter widths
	// =====================================================================
	localparam logic [7:0]  THRESH_MIN       = 8'h01;
	localparam logic [7:0]  UF_COUNT_MAX     = 8'hFF;
	localparam logic [1:0]  PARK_ZERO        = 2'h0;
	localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

	// =====================================================================
	// carriers
	// =====================================================================
	typedef struct packed {
		logic       run;
		logic       async_enable;
		logic       doorbell;
		logic       park_enable;
		logic [1:0] park_count;
		logic [7:0] threshold;
	} sched_ctrl_t;

	typedef struct packed {
		logic cache_evicted;
		logic txn_done;
		logic qh_high_speed;
		logic uframe_tick;
		logic irq_cause;
	} sched_evt_t;

	typedef struct packed {
		logic [31:0] cmd;
		logic        adv_flag;
		logic [31:0] rdata;
	} bank_state_t;

	typedef struct packed {
		logic [1:0] txn_count;
	} park_state_t;

	typedef struct packed {
		logic       pending;
		logic [7:0] uf_count;
		logic       fire;
	} gate_state_t;

endpackage : hc_cmd_pkg

`default_nettype wire

/* src/park_counter.sv */
/*
  park mode counter: counts back-to-back transactions on one queue head
  and tells the schedule engine when to move to the next queue head.
  assumes txn_done is a one-cycle pulse from the schedule engine.
*/
`timescale 1ns/100ps
`default_nettype none

module park_counter
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire hc_cmd_pkg::sched_ctrl_t ctrl,
	input  wire logic               txn_done,
	input  wire logic               qh_high_speed,
	output logic                    advance_qh
);

	// =====================================================================
	// state
	// =====================================================================
	hc_cmd_pkg::park_state_t state_reg;
	hc_cmd_pkg::park_state_t state_next;
	logic                    advance_next;
	logic [1:0]              limit;

	always_comb
	begin
		state_next   = state_reg;
		advance_next = 1'b0;
		// a zero count is treated as one transaction per visit
		limit = (ctrl.park_count == hc_cmd_pkg::PARK_ZERO) ?
			2'h1 : ctrl.park_count;
		if (!ctrl.async_enable)
		begin
			state_next.txn_count = hc_cmd_pkg::PARK_ZERO;
		end
		else if (txn_done)
		begin
			if (ctrl.park_enable && qh_high_speed &&
				(state_reg.txn_count + 2'h1) < limit)
			begin
				state_next.txn_count = state_reg.txn_count + 2'h1;
			end
			else
			begin
				state_next.txn_count = hc_cmd_pkg::PARK_ZERO;
				advance_next         = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg  <= '0;
			advance_qh <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			advance_qh <= advance_next;
		end
	end

endmodule : park_counter

`default_nettype wire

/* src/irq_throttle.sv */
/*
  interrupt throttle: holds pending interrupt causes and releases them
  at a micro-frame boundary no more often than the programmed interval.
  assumes uframe_tick pulses once per 125 us micro-frame.
*/
`timescale 1ns/100ps
`default_nettype none

module irq_throttle
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] threshold,
	input  wire logic       uframe_tick,
	input  wire logic       cause,
	output logic            interrupt_issue
);

	hc_cmd_pkg::gate_state_t state_reg;
	hc_cmd_pkg::gate_state_t state_next;
	logic [7:0]              interval;

	always_comb
	begin
		state_next      = state_reg;
		state_next.fire = 1'b0;
		// reserved zero code behaves as one micro-frame
		interval = (threshold == 8'h00) ? hc_cmd_pkg::THRESH_MIN : threshold;
		if (cause)
		begin
			state_next.pending = 1'b1;
		end
		if (uframe_tick)
		begin
			if (state_reg.uf_count != hc_cmd_pkg::UF_COUNT_MAX)
			begin
				state_next.uf_count = state_reg.uf_count + 8'h01;
			end
			if (state_next.pending && state_next.uf_count >= interval)
			begin
				state_next.fire     = 1'b1;
				state_next.pending  = 1'b0;
				state_next.uf_count = 8'h00;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// saturated count so the first cause is not held back
			state_reg <= '{pending: 1'b0,
				uf_count: hc_cmd_pkg::UF_COUNT_MAX, fire: 1'b0};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign interrupt_issue = state_reg.fire;

endmodule : irq_throttle

`default_nettype wire

/* src/hc_cmd_bank.sv */
/*
  command / status register bank of the host controller behind APB:
  doorbell handshake, park mode controls, interrupt threshold.
  assumes an APB master on pclk and a schedule engine that reports
  cache eviction, transaction completion and micro-frame ticks.
*/
//
// Overview of operation
// - doorbell pending plus cache evicted sets async-advance status flag
// - doorbell bit cleared by hardware once status flag is set
// - bit 7 light reset unsupported, reads zero, writes ignored
// - bits 9:8 park count, read/write, reset 11b
// - bit 11 park enable, read/write, reset one
// - bits 23:16 threshold, reset 08h, limits interrupt rate
// - threshold codes give interval in micro-frames directly
// - command bit 5 gates asynchronous schedule processing
// - status flag clears only on write of one
`timescale 1ns/100ps
`default_nettype none

module hc_cmd_bank
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire hc_cmd_pkg::sched_evt_t  evt,
	output hc_cmd_pkg::sched_ctrl_t      ctrl,
	output logic                         async_run,
	output logic                         advance_qh,
	output logic                         interrupt_issue
);

	// =====================================================================
	// state and decode
	// =====================================================================
	hc_cmd_pkg::bank_state_t state_reg;
	hc_cmd_pkg::bank_state_t state_next;
	logic [31:0]             lane_mask;
	logic                    hit_cmd;
	logic                    hit_sts;
	logic                    wr_access;
	logic                    rd_setup;
	logic                    adv_set;
	logic [31:0]             wr_bits;

	assign hit_cmd   = (paddr == hc_cmd_pkg::CMD_OFFSET);
	assign hit_sts   = (paddr == hc_cmd_pkg::STS_OFFSET);
	assign wr_access = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;

	// =====================================================================
	// byte lanes
	// =====================================================================
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++)
		begin : g_lane
			assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
		end
	endgenerate

	assign wr_bits = pwdata & lane_mask;

	// =====================================================================
	// next state
	// =====================================================================
	always_comb
	begin
		state_next = state_reg;
		adv_set    = 1'b0;

		// only documented storage bits take writes; 7, 10, 15:12,
		// 31:24 stay zero forever
		if (wr_access && hit_cmd)
		begin
			state_next.cmd = (state_reg.cmd &
				~(hc_cmd_pkg::CMD_RW_MASK & lane_mask)) |
				(wr_bits & hc_cmd_pkg::CMD_RW_MASK);
		end

		// doorbell handshake with the schedule engine
		if (state_reg.cmd[hc_cmd_pkg::CMD_DOORBELL_BIT] &&
			evt.cache_evicted)
		begin
			adv_set = 1'b1;
			state_next.cmd[hc_cmd_pkg::CMD_DOORBELL_BIT] = 1'b0;
		end

		// a fresh ring in the same cycle as the hardware clear survives
		if (wr_access && hit_cmd &&
			|(wr_bits & hc_cmd_pkg::CMD_DOORBELL_MSK))
		begin
			state_next.cmd[hc_cmd_pkg::CMD_DOORBELL_BIT] = 1'b1;
		end

		// write-one-to-clear; a set in the same cycle wins
		if (wr_access && hit_sts && wr_bits[hc_cmd_pkg::STS_ASYNC_ADV_BIT])
		begin
			state_next.adv_flag = 1'b0;
		end
		if (adv_set)
		begin
			state_next.adv_flag = 1'b1;
		end

		// read data sampled in setup so prdata is a flop in access
		if (rd_setup)
		begin
			if (hit_cmd)
			begin
				state_next.rdata = state_reg.cmd;
			end
			else if (hit_sts)
			begin
				state_next.rdata = hc_cmd_pkg::RDATA_RESET;
				state_next.rdata[hc_cmd_pkg::STS_ASYNC_ADV_BIT] =
					state_reg.adv_flag;
			end
			else
			begin
				state_next.rdata = hc_cmd_pkg::RDATA_RESET;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg.cmd      <= hc_cmd_pkg::CMD_RESET;
			state_reg.adv_flag <= hc_cmd_pkg::STS_FLAG_RESET;
			state_reg.rdata    <= hc_cmd_pkg::RDATA_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// =====================================================================
	// APB answer: zero wait, error on unmapped address
	// =====================================================================
	assign prdata  = state_reg.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(hit_cmd || hit_sts);

	// =====================================================================
	// control to the schedule engine
	// =====================================================================
	assign ctrl.run          = state_reg.cmd[hc_cmd_pkg::CMD_RUN_BIT];
	assign ctrl.async_enable = state_reg.cmd[hc_cmd_pkg::CMD_ASYNC_EN_BIT];
	assign ctrl.doorbell     = state_reg.cmd[hc_cmd_pkg::CMD_DOORBELL_BIT];
	assign ctrl.park_enable  = state_reg.cmd[hc_cmd_pkg::CMD_PARK_EN_BIT];
	assign ctrl.park_count   =
		state_reg.cmd[hc_cmd_pkg::CMD_PARK_CNT_LO +: 2];
	assign ctrl.threshold    =
		state_reg.cmd[hc_cmd_pkg::CMD_THRESH_LO +: 8];
	// schedule skipped entirely while bit 5 is low
	assign async_run = ctrl.run && ctrl.async_enable;

	// =====================================================================
	// park mode and interrupt rate
	// =====================================================================
	park_counter u_park
	(
		.pclk          (pclk),
		.presetn       (presetn),
		.ctrl          (ctrl),
		.txn_done      (evt.txn_done && async_run),
		.qh_high_speed (evt.qh_high_speed),
		.advance_qh    (advance_qh)
	);

	// doorbell completion waits for the next threshold boundary
	irq_throttle u_throttle
	(
		.pclk            (pclk),
		.presetn         (presetn),
		.threshold       (ctrl.threshold),
		.uframe_tick     (evt.uframe_tick),
		.cause           (evt.irq_cause || adv_set),
		.interrupt_issue (interrupt_issue)
	);

endmodule : hc_cmd_bank

`default_nettype wire

/* dv/hc_cmd_bank_properties.sv */
/*
  concurrent checks on the ports of the command / status bank.
  assumes a single pclk domain, bound onto every hc_cmd_bank instance.
*/
`timescale 1ns/100ps
`default_nettype none

module hc_cmd_bank_properties
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire hc_cmd_pkg::sched_evt_t  evt,
	input wire hc_cmd_pkg::sched_ctrl_t ctrl,
	input wire logic                    async_run,
	input wire logic                    advance_qh,
	input wire logic                    interrupt_issue
);
	// =====================================================
	// helpers
	// =====================================================
	logic       wr;
	logic       ring;
	logic [7:0] ticks;
	logic [7:0] thr;
	assign wr = psel && penable && pwrite && pready && paddr == 8'h20;
	assign ring = wr && pstrb[0] && pwdata[6];
	assign thr = (ctrl.threshold == 8'h00) ? 8'h01 : ctrl.threshold;
	// starts saturated: first cause may fire at once
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ticks <= 8'hFF;
		else if (interrupt_issue)
			ticks <= {7'h00, evt.uframe_tick};
		else if (evt.uframe_tick && ticks != 8'hFF)
			ticks <= ticks + 8'h01;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// =====================================================
	// properties
	// =====================================================
	property p_ring; ring |=> ctrl.doorbell; endproperty
	a_ring: assert property (p_ring) else $error("doorbell not set");
	property p_clear;
		ctrl.doorbell && evt.cache_evicted && !ring |=> !ctrl.doorbell;
	endproperty
	a_clear: assert property (p_clear) else $error("doorbell stuck");
	property p_bit7; !prdata[7]; endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 not zero");
	property p_resv;
		prdata[31:24] == 8'h00 && prdata[15:12] == 4'h0 && !prdata[10];
	endproperty
	a_resv: assert property (p_resv) else $error("reserved set");
	property p_park;
		wr && pstrb[1] |=> ctrl.park_count == $past(pwdata[9:8])
			&& ctrl.park_enable == $past(pwdata[11]);
	endproperty
	a_park: assert property (p_park) else $error("park field");
	property p_thr;
		wr && pstrb[2] |=> ctrl.threshold == $past(pwdata[23:16]);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold field");
	property p_run; async_run == (ctrl.run && ctrl.async_enable); endproperty
	a_run: assert property (p_run) else $error("async gate");
	property p_adv;
		evt.txn_done && async_run && !ctrl.park_enable |-> ##[0:1] advance_qh;
	endproperty
	a_adv: assert property (p_adv) else $error("no advance");
	property p_adv_src; advance_qh |-> $past(evt.txn_done); endproperty
	a_adv_src: assert property (p_adv_src) else $error("stray advance");
	property p_rate; interrupt_issue |-> ticks >= thr; endproperty
	a_rate: assert property (p_rate) else $error("interrupt too soon");
	property p_tick; interrupt_issue |-> $past(evt.uframe_tick); endproperty
	a_tick: assert property (p_tick) else $error("off boundary");
	c_clear: cover property (ctrl.doorbell && evt.cache_evicted);
	c_irq: cover property (interrupt_issue);
	c_adv: cover property (advance_qh);
endmodule : hc_cmd_bank_properties

bind hc_cmd_bank hc_cmd_bank_properties hc_cmd_bank_properties_i
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
	.ctrl(ctrl), .async_run(async_run), .advance_qh(advance_qh),
	.interrupt_issue(interrupt_issue)
);

`default_nettype wire

/* dv/test_hc_cmd_bank.sv */
/*
  self-checking bench for the command / status bank over APB.
  assumes zero-wait slave; events driven straight into evt.
*/
`timescale 1ns/100ps
`default_nettype none

module test_hc_cmd_bank;
	logic                    pclk, presetn, psel, penable, pwrite;
	logic                    pready, pslverr, async_run, advance_qh, irq;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, rd;
	logic [3:0]              pstrb;
	logic                    err;
	hc_cmd_pkg::sched_evt_t  evt;
	hc_cmd_pkg::sched_ctrl_t ctrl;
	int                      fail_count, compares, adv_n, irq_n, a, k;
	logic [7:0]              cfg [3] = '{8'h0B, 8'h01, 8'h0A};
	int                      txn [3] = '{3, 2, 4};
	int                      exp_adv [3] = '{1, 2, 2};

	hc_cmd_bank hc_cmd_bank_i
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
		.ctrl(ctrl), .async_run(async_run), .advance_qh(advance_qh),
		.interrupt_issue(irq)
	);

	// =====================================================
	// clock, monitors, tasks
	// =====================================================
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		if (advance_qh === 1'b1) adv_n++;
		if (irq === 1'b1) irq_n++;
	end

	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w;
		paddr <= ad; pwdata <= d; pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a stalled wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : xfer

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// pulse, then three quiet cycles before the next one
	task automatic ev(input logic [4:0] m, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			evt <= hc_cmd_pkg::sched_evt_t'(evt | m);
			@(posedge pclk);
			evt <= hc_cmd_pkg::sched_evt_t'(evt & ~m);
			repeat (2) @(posedge pclk);
		end
	endtask : ev

	task automatic test_done;
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	initial
	begin
		#200000;
		fail_count++;
		test_done();
	end

	// =====================================================
	// tests
	// =====================================================
	initial
	begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
		evt = hc_cmd_pkg::sched_evt_t'(5'h04);
		fail_count = 0; compares = 0; adv_n = 0; irq_n = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 8'h20, 32'h0, 4'h0);
		chk("cmd reset", rd, 32'h0008_0B00);
		xfer(1'b0, 8'h24, 32'h0, 4'h0);
		chk("sts reset", rd, 32'h0000_0000);
		// threshold byte kept to a legal code
		xfer(1'b1, 8'h20, 32'hFF40_FFFF, 4'hF);
		xfer(1'b0, 8'h20, 32'h0, 4'h0);
		chk("cmd ones", rd, 32'h0040_0B7F);
		chk("doorbell", ctrl.doorbell, 32'h1);
		chk("async run", async_run, 32'h1);
		ev(5'h10, 1);
		a = irq_n;
		ev(5'h02, 1);
		chk("advance irq", 32'(irq_n - a), 32'h1);
		xfer(1'b0, 8'h24, 32'h0, 4'h0);
		chk("adv flag", rd, 32'h0000_0020);
		chk("sts err", err, 32'h0);
		xfer(1'b0, 8'h20, 32'h0, 4'h0);
		chk("doorbell off", rd, 32'h0040_0B3F);
		xfer(1'b0, 8'h28, 32'h0, 4'h0);
		chk("unmapped data", rd, 32'h0000_0000);
		chk("unmapped err", err, 32'h1);
		xfer(1'b1, 8'h24, 32'h0, 4'hF);
		xfer(1'b0, 8'h24, 32'h0, 4'h0);
		chk("flag hold", rd, 32'h0000_0020);
		xfer(1'b1, 8'h24, 32'h20, 4'hF);
		xfer(1'b0, 8'h24, 32'h0, 4'h0);
		chk("flag clear", rd, 32'h0000_0000);
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, 8'h20, {16'h0, cfg[i], 8'h00}, 4'h2);
			a = adv_n;
			ev(5'h08, txn[i]);
			chk("park adv", 32'(adv_n - a), 32'(exp_adv[i]));
		end
		xfer(1'b1, 8'h20, 32'h0, 4'h1);
		// register settles in the write edge's update
		@(posedge pclk);
		chk("async off", async_run, 32'h0);
		a = adv_n;
		ev(5'h08, 2);
		chk("park idle", 32'(adv_n - a), 32'h0);
		// 64 ticks at every legal code; minimum spacing is the checker's job
		for (int c = 1; c <= 64; c = c * 2)
		begin
			xfer(1'b1, 8'h20, {8'h00, 8'(c), 16'h0}, 4'h4);
			a = irq_n;
			k = 64 / c;
			ev(5'h03, 64);
			chk("irq rate", 32'(irq_n - a >= k - 1 && irq_n - a <= k + 1),
				32'h1);
		end
		// second reset in mid-run must restore the defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 8'h20, 32'h0, 4'h0);
		chk("cmd re-reset", rd, 32'h0008_0B00);
		xfer(1'b0, 8'h24, 32'h0, 4'h0);
		chk("sts re-reset", rd, 32'h0000_0000);
		test_done();
	end
endmodule : test_hc_cmd_bank

`default_nettype wire
